// ===== sso_status_out.sv
// status, warning, brake interlock and alarm-code output logic
// Operation
// - brake interlock off while servo off or any alarm present
// - brake interlock enabled makes zero-speed output unavailable
// - pin assigned to warning or battery warning loses its old signal
// - warning output on while any warning exists
// - warning output off within about 1.5 s of power-on if none
// - battery warning on for cable-disconnected or low-battery warning
// - battery warning off within about 1.5 s of power-on if none
// - code enable makes three pins carry the alarm code during an alarm
// - without alarm the three pins carry their ordinary status signals
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module sso_status_out #(
	parameter int SETTLE_CYC = sso_pkg::WARN_SETTLE_CYC
) (
	// clock and reset
	input  wire logic               mclk_i,
	input  wire logic               rst_n_i,
	input  wire logic               ce_i,
	// register port
	input  wire logic [7:0]         addr_i,
	input  wire logic [31:0]        wdata_i,
	input  wire logic               wr_i,
	input  wire logic               rd_i,
	output logic      [31:0]        rdata_o,
	// drive core conditions
	input  wire sso_pkg::sso_motion_s motion_i,
	input  wire sso_pkg::sso_fault_s  fault_i,
	// dedicated status outputs
	output logic                    brake_interlock_out_o,
	output logic                    warning_flag_out_o,
	output logic                    battery_warning_out_o,
	output logic                    zero_speed_out_o,
	// shared pins: ordinary status or alarm code
	output logic                    fault_code_bit0_o,
	output logic                    fault_code_bit1_o,
	output logic                    fault_code_bit2_o
);
	localparam logic [sso_pkg::SETTLE_W-1:0] SETTLE_LAST =
		sso_pkg::SETTLE_W'(SETTLE_CYC - 1);

	function automatic logic [2:0] fault_group(input sso_pkg::sso_cause_e c);
		unique case (c)
			sso_pkg::CAUSE_WATCHDOG, sso_pkg::CAUSE_MEMORY, sso_pkg::CAUSE_CLOCK,
			sso_pkg::CAUSE_BOARD, sso_pkg::CAUSE_PARAM,
			sso_pkg::CAUSE_SERIAL:    fault_group = sso_pkg::CODE_SYSTEM;
			sso_pkg::CAUSE_REGEN,
			sso_pkg::CAUSE_OVERVOLT:  fault_group = sso_pkg::CODE_OVERV;
			sso_pkg::CAUSE_UNDERVOLT: fault_group = sso_pkg::CODE_UNDERV;
			default:                  fault_group = sso_pkg::CODE_OTHER;
		endcase
	endfunction

	function automatic logic pin_pick(input logic [2:0] sel, input logic [7:0] fns,
		input logic dflt);
		pin_pick = (sel == sso_pkg::PIN_FN_DEFAULT) ? dflt : fns[sel];
	endfunction

	logic [1:0]                   ctrl_reg;
	logic [8:0]                   pinmap_reg;
	logic [sso_pkg::SETTLE_W-1:0] settle_cnt_reg;
	logic                         settle_done_reg;
	logic [31:0]                  rdata_reg;
	logic [2:0]                   pins_reg;
	logic                         brake_reg;
	logic                         warn_reg;
	logic                         batt_reg;
	logic                         zspd_reg;

	wire wr_ctrl   = ce_i && wr_i && (addr_i == sso_pkg::CTRL_OFS);
	wire wr_pinmap = ce_i && wr_i && (addr_i == sso_pkg::PINMAP_OFS);

	// brake is usable when enabled directly or routed to any shared pin
	wire [2:0] pin_is_brake;
	wire       brake_routed = |pin_is_brake;
	wire       brake_used   = ctrl_reg[sso_pkg::CTRL_BRAKE_EN_BIT] | brake_routed;
	wire       code_en      = ctrl_reg[sso_pkg::CTRL_CODE_EN_BIT];

	wire brake_next = motion_i.servo_on && !fault_i.alarm;
	wire zspd_next  = motion_i.zero_speed && !brake_used;
	// outputs stand on through the settle window, then follow the condition
	wire warn_next  = settle_done_reg ? fault_i.warn_any : 1'b1;
	wire batt_cond  = fault_i.batt_cable || fault_i.batt_low;
	wire batt_next  = settle_done_reg ? batt_cond : 1'b1;

	wire [7:0] fn_vec = {batt_reg, warn_reg, brake_reg, zspd_reg,
		motion_i.speed_reached, motion_i.in_position, motion_i.ready, 1'b0};
	wire [2:0] dflt_vec  = {motion_i.ready, zspd_reg, motion_i.in_position};
	wire [2:0] code_vec  = fault_group(fault_i.cause);
	wire       show_code = code_en && fault_i.alarm;
	wire [2:0] pins_next;

	genvar gi;
	generate
		for (gi = 0; gi < sso_pkg::PIN_CNT; gi++) begin : g_pin
			wire [2:0] sel = pinmap_reg[gi*sso_pkg::PIN_SEL_W +: sso_pkg::PIN_SEL_W];
			assign pin_is_brake[gi] = (sel == sso_pkg::PIN_FN_BRAKE);
			// an assigned function replaces the pin's old signal
			assign pins_next[gi] = show_code ? code_vec[gi]
				: pin_pick(sel, fn_vec, dflt_vec[gi]);
		end
	endgenerate

	wire [31:0] status_word = {22'h000000, settle_done_reg, pins_reg, zspd_reg,
		batt_reg, warn_reg, brake_reg, brake_used, show_code};
	wire [31:0] rd_mux =
		(addr_i == sso_pkg::CTRL_OFS)   ? {30'h00000000, ctrl_reg} :
		(addr_i == sso_pkg::PINMAP_OFS) ? {23'h000000, pinmap_reg} :
		(addr_i == sso_pkg::STATUS_OFS) ? status_word : 32'h00000000;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_reg   <= sso_pkg::CTRL_RST;
			pinmap_reg <= sso_pkg::PINMAP_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= wdata_i[1:0];
			end
			if (wr_pinmap) begin
				pinmap_reg <= wdata_i[8:0];
			end
		end
	end

	// the settle counter runs once after power-on; a long count is cheap here
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			settle_cnt_reg  <= '0;
			settle_done_reg <= 1'b0;
		end else if (ce_i && !settle_done_reg) begin
			settle_cnt_reg  <= settle_cnt_reg + 1'b1;
			settle_done_reg <= (settle_cnt_reg == SETTLE_LAST);
		end
	end

	// every output is a flop holding a level for as long as its cause holds, except warning and battery warning, which stand on through the settle window
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			brake_reg <= 1'b0;
			warn_reg  <= 1'b1;
			batt_reg  <= 1'b1;
			zspd_reg  <= 1'b0;
			pins_reg  <= 3'h0;
			rdata_reg <= 32'h00000000;
		end else if (ce_i) begin
			brake_reg <= brake_next;
			warn_reg  <= warn_next;
			batt_reg  <= batt_next;
			zspd_reg  <= zspd_next;
			pins_reg  <= pins_next;
			rdata_reg <= rd_i ? rd_mux : 32'h00000000;
		end
	end

	assign rdata_o               = rdata_reg;
	assign brake_interlock_out_o = brake_reg;
	assign warning_flag_out_o    = warn_reg;
	assign battery_warning_out_o = batt_reg;
	assign zero_speed_out_o      = zspd_reg;
	assign fault_code_bit0_o     = pins_reg[0];
	assign fault_code_bit1_o     = pins_reg[1];
	assign fault_code_bit2_o     = pins_reg[2];

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	chk_brake_alarm_off: assert property (
		ce_i && fault_i.alarm |=> !brake_interlock_out_o)
		else $error("brake interlock on during alarm");
	chk_brake_servo_off: assert property (
		ce_i && !motion_i.servo_on |=> !brake_interlock_out_o)
		else $error("brake interlock on with servo off");
	chk_zspd_blocked: assert property (
		ce_i && brake_used |=> !zero_speed_out_o)
		else $error("zero speed output shown while brake interlock used");
	chk_warn_follows: assert property (
		ce_i && settle_done_reg |=> warning_flag_out_o == $past(fault_i.warn_any))
		else $error("warning output does not follow warning condition");
	chk_warn_settle: assert property (
		ce_i && !fault_i.warn_any && settle_done_reg ##1 ce_i && !fault_i.warn_any
		|=> !warning_flag_out_o)
		else $error("warning output still on after settle");
	chk_batt_follows: assert property (
		ce_i && settle_done_reg && (fault_i.batt_cable || fault_i.batt_low)
		|=> battery_warning_out_o)
		else $error("battery warning missing");
	chk_batt_settle: assert property (
		ce_i && settle_done_reg && !fault_i.batt_cable && !fault_i.batt_low
		|=> !battery_warning_out_o)
		else $error("battery warning on without cause");
	chk_code_shown: assert property (
		ce_i && code_en && fault_i.alarm |=> pins_reg == $past(code_vec))
		else $error("alarm code not on shared pins");
	chk_code_group: assert property (
		ce_i && show_code && fault_i.cause == sso_pkg::CAUSE_UNDERVOLT
		|=> pins_reg == sso_pkg::CODE_UNDERV)
		else $error("undervoltage code wrong");
	chk_ordinary_pins: assert property (
		ce_i && !fault_i.alarm && pinmap_reg == 9'h000
		|=> fault_code_bit0_o == $past(motion_i.in_position))
		else $error("ordinary signal missing on shared pin");
	chk_pin_assign: assert property (
		ce_i && !show_code && pinmap_reg[2:0] == sso_pkg::PIN_FN_WARN
		|=> fault_code_bit0_o == $past(warn_reg))
		else $error("assigned warning not on pin");
	chk_warn_level: assert property (
		ce_i && settle_done_reg && fault_i.warn_any ##1 ce_i && fault_i.warn_any
		|=> warning_flag_out_o && $past(warning_flag_out_o))
		else $error("warning output pulsed");

	cov_alarm_code: cover property (code_en && fault_i.alarm ##1 pins_reg == sso_pkg::CODE_OVERV);
	cov_settle_end: cover property ($rose(settle_done_reg));
	cov_brake_drop: cover property (brake_interlock_out_o ##1 !brake_interlock_out_o);
endmodule
`default_nettype wire

// ===== sso_pkg.sv
// shared constants, types and register map for the servo status outputs
`default_nettype none
package sso_pkg;
	// register map (byte offsets)
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] PINMAP_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	// control register fields
	localparam int CTRL_BRAKE_EN_BIT = 0;
	localparam int CTRL_CODE_EN_BIT  = 1;
	localparam logic [1:0] CTRL_RST  = 2'h0;
	// pin map: three 3-bit function fields, pin n at bits 3n+2..3n
	localparam int PIN_SEL_W = 3;
	localparam int PIN_CNT   = 3;
	localparam logic [8:0] PINMAP_RST = 9'h000;
	// power-on settle time for the warning outputs
	localparam int CLK_HZ         = 20_000_000;
	localparam int WARN_SETTLE_MS = 1500;
	localparam int WARN_SETTLE_CYC = (CLK_HZ / 1000) * WARN_SETTLE_MS;
	localparam int SETTLE_W = 25;

	typedef enum logic [2:0] {
		PIN_FN_DEFAULT = 3'h0,
		PIN_FN_READY   = 3'h1,
		PIN_FN_INPOS   = 3'h2,
		PIN_FN_SPEED   = 3'h3,
		PIN_FN_ZSPD    = 3'h4,
		PIN_FN_BRAKE   = 3'h5,
		PIN_FN_WARN    = 3'h6,
		PIN_FN_BATT    = 3'h7
	} sso_pin_fn_e;

	typedef enum logic [3:0] {
		CAUSE_WATCHDOG  = 4'h0,
		CAUSE_MEMORY    = 4'h1,
		CAUSE_CLOCK     = 4'h2,
		CAUSE_BOARD     = 4'h3,
		CAUSE_PARAM     = 4'h4,
		CAUSE_SERIAL    = 4'h5,
		CAUSE_REGEN     = 4'h6,
		CAUSE_OVERVOLT  = 4'h7,
		CAUSE_UNDERVOLT = 4'h8,
		CAUSE_OTHER     = 4'hF
	} sso_cause_e;

	localparam logic [2:0] CODE_SYSTEM = 3'h0;
	localparam logic [2:0] CODE_OVERV  = 3'h1;
	localparam logic [2:0] CODE_UNDERV = 3'h2;
	localparam logic [2:0] CODE_OTHER  = 3'h7;

	// ordinary status flags from the drive core
	typedef struct packed {
		logic servo_on;
		logic ready;
		logic in_position;
		logic speed_reached;
		logic zero_speed;
	} sso_motion_s;

	// alarm and warning conditions from the protection logic
	typedef struct packed {
		logic       alarm;
		sso_cause_e cause;
		logic       warn_any;
		logic       batt_cable;
		logic       batt_low;
	} sso_fault_s;
endpackage
`default_nettype wire

// ===== sso_host_model.sv
// host controller model: latches the discrete status outputs
`timescale 1ns/100ps
`default_nettype none
module sso_host_model (
	input  wire logic       mclk_i,
	input  wire logic [6:0] pins_i,
	output logic      [6:0] seen_o
);
	// one register stage, as an input card filters before the host reads it
	always_ff @(posedge mclk_i) begin
		seen_o <= pins_i;
	end
endmodule
`default_nettype wire

// ===== sso_status_out_tb_top.sv
// self-checking testbench for the servo status outputs
`timescale 1ns/100ps
`default_nettype none
module sso_status_out_tb_top;
	localparam int SETTLE = 16;
	logic                 mclk_i = 0, rst_n_i = 0, ce_i = 1, wr_i = 0, rd_i = 0;
	logic                 smp = 0, rd_d = 0, brk, wrn, bat, zero_speed_out, p0, p1, p2;
	logic [7:0]           addr_i = 8'h00;
	logic [31:0]          wdata_i = 32'h0, rdata_o;
	sso_pkg::sso_motion_s mo = '0, rm;
	sso_pkg::sso_fault_s  fl = '0;
	logic [6:0]           seen;
	logic [13:0]          exp_q[$], note;
	logic [31:0]          rd_q[$];
	logic [3:0]           causes[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hF};
	int                   mismatches = 0, cmp_count = 0, i;

	sso_status_out #(.SETTLE_CYC(SETTLE)) i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.motion_i(mo), .fault_i(fl), .brake_interlock_out_o(brk), .warning_flag_out_o(wrn),
		.battery_warning_out_o(bat), .zero_speed_out_o(zero_speed_out), .fault_code_bit0_o(p0),
		.fault_code_bit1_o(p1), .fault_code_bit2_o(p2));
	sso_host_model i_host (.mclk_i(mclk_i), .pins_i({brk, wrn, bat, zero_speed_out, p2, p1, p0}),
		.seen_o(seen));

	initial begin
		forever #25 mclk_i = ~mclk_i;
	end

	function automatic logic [2:0] code_of(input logic [3:0] c);
		if (c <= 4'h5) return sso_pkg::CODE_SYSTEM;
		if (c <= 4'h7) return sso_pkg::CODE_OVERV;
		if (c == 4'h8) return sso_pkg::CODE_UNDERV;
		return sso_pkg::CODE_OTHER;
	endfunction

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: seen 0x%0h, expected 0x%0h", $time, got, exp);
		end
	endtask

	// note: mask in the upper half, expected outputs in the lower half
	task automatic check_out(input logic [6:0] m, input logic [6:0] e);
		exp_q.push_back({m, e});
		smp <= 1'b1;
		@(posedge mclk_i);
		smp <= 1'b0;
	endtask

	task automatic settle();
		repeat (4) @(posedge mclk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk_i);
		rd_q.push_back(e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
	endtask

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	always @(posedge mclk_i) rd_d <= rd_i & ce_i;

	// results appear a fixed time after each note, so the oldest note always matches
	always @(negedge mclk_i) begin
		if (smp) begin
			note = exp_q.pop_front();
			cmp({25'h0, seen & note[13:7]}, {25'h0, note[6:0] & note[13:7]});
		end
		if (rd_d) cmp(rdata_o, rd_q.pop_front());
	end

	initial begin
		repeat (5000) @(posedge mclk_i);
		mismatches++;
		finish_test();
	end

	initial begin
		void'($urandom(32'hB7FD));
		repeat (8) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		check_out(7'h30, 7'h30);
		repeat (SETTLE + 4) @(posedge mclk_i);
		check_out(7'h7F, 7'h00);
		for (i = 0; i < 3; i++) begin
			fl.warn_any <= (i == 0);
			fl.batt_cable <= (i == 1);
			fl.batt_low <= (i == 2);
			settle();
			check_out(7'h30, {1'b0, i == 0, i != 0, 4'h0});
		end
		fl <= '0;
		wr(sso_pkg::CTRL_OFS, 32'h1);
		mo.servo_on <= 1'b1;
		mo.zero_speed <= 1'b1;
		settle();
		check_out(7'h48, 7'h40);
		fl.alarm <= 1'b1;
		settle();
		check_out(7'h40, 7'h00);
		fl.alarm <= 1'b0;
		mo.servo_on <= 1'b0;
		settle();
		check_out(7'h48, 7'h00);
		wr(sso_pkg::CTRL_OFS, 32'h2);
		for (i = 0; i < 10; i++) begin
			fl.alarm <= 1'b1;
			fl.cause <= sso_pkg::sso_cause_e'(causes[i]);
			mo <= sso_pkg::sso_motion_s'(5'($urandom));
			settle();
			check_out(7'h07, {4'h0, code_of(causes[i])});
			repeat (5) @(posedge mclk_i);
			check_out(7'h07, {4'h0, code_of(causes[i])});
		end
		fl <= '0;
		for (i = 0; i < 8; i++) begin
			rm = sso_pkg::sso_motion_s'(5'($urandom));
			mo <= rm;
			settle();
			check_out(7'h0F, {3'h0, rm.zero_speed, rm.ready, rm.zero_speed, rm.in_position});
		end
		wr(sso_pkg::PINMAP_OFS, 32'h6);
		// in position only, so a stale ordinary signal on pin 0 would show
		mo <= 5'h04;
		fl.warn_any <= 1'b1;
		settle();
		check_out(7'h21, 7'h21);
		fl.warn_any <= 1'b0;
		settle();
		check_out(7'h21, 7'h00);
		// pin 0 warning, pin 1 brake interlock, pin 2 battery warning
		wr(sso_pkg::PINMAP_OFS, 32'h1EE);
		mo <= 5'h11;
		fl.batt_low <= 1'b1;
		settle();
		check_out(7'h4F, 7'h46);
		ce_i <= 1'b0;
		wr(sso_pkg::CTRL_OFS, 32'h1);
		ce_i <= 1'b1;
		rd(sso_pkg::CTRL_OFS, 32'h2);
		rd(sso_pkg::PINMAP_OFS, 32'h1EE);
		rd(8'hFC, 32'h0);
		// settle done, pins 110, battery, brake, brake routed
		rd(sso_pkg::STATUS_OFS, 32'h396);
		settle();
		finish_test();
	end
endmodule
`default_nettype wire
